// ===== rtl/host_port_match_n_port_logic.sv
// Host wake-up port, bus-cycle decode and lane steering of the disk controller
`timescale 1ns/1ps
`include "wake_port_regs.svh"
module host_port_match_n_port_logic (
  // Clock and asynchronous reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Processor bus cycle, address and data
  input wire wake_port_pkg::cycle_e cycle_status_i,
  input wire logic ale_i,
  input wire logic [19:0] proc_addr_i,
  input wire logic [15:0] proc_data_i,
  // Transceiver controls from the bus cycle logic
  input wire logic dt_r_i,
  input wire logic den_i,
  input wire logic local_xcvr_enable_n_n_i,
  // Memory width and local interrupt port write
  input wire logic mem_16bit_i,
  input wire logic irq_port_write_n_i,
  // Host I/O write cycle
  input wire logic host_io_write_i,
  input wire logic [15:0] host_io_addr_i,
  input wire logic [7:0] host_data_i,
  // Board jumpers
  input wire logic [15:0] wake_jumper_i,
  input wire logic io_16bit_jumper_i,
  input wire logic width_16_jumper_i,
  input wire logic last_page_jumper_i,
  // Command strobes, low active
  output logic inta_n_o,
  output logic io_read_n_o,
  output logic local_write_strobe_n_o,
  output logic mem_read_n_o,
  output logic mem_write_n_o,
  // Latched address and transceiver controls
  output logic [19:0] sys_addr_o,
  output logic [19:0] local_addr_o,
  output logic xcvr_direction_o,
  output logic system_xcvr_enable_o,
  output logic local_xcvr_enable_n_o,
  // Byte lane enables, low active
  output logic high_lane_enable_n_o,
  output logic low_lane_enable_n_o,
  output logic swap_lane_enable_n_o,
  // Wake-up port results and host interrupt
  output logic port_match_n_o,
  output logic board_reset_n_o,
  output logic attention_input_o,
  output logic host_irq_n_o,
  // Answers to initialization fetches and page select
  output logic jumper_read_gate_n_o,
  output logic init_ack_o,
  output logic [15:0] init_data_o,
  output logic block_page_last_o
);
  import wake_port_pkg::*;

  state_s st;
  state_s next_st;
  logic rst_n;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Wake-up address compare, upper byte forced equal in 8-bit mode
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] j,
                                    input logic wide);
    logic hi_ok;
    hi_ok = !wide || (a[15:8] == j[15:8]);
    return hi_ok && (a[7:0] == j[7:0]);
  endfunction

  // Bus command strobes from the processor status code
  function automatic cmd_s decode_cycle(input cycle_e c);
    cmd_s r;
    r = '{default: 1'b1};
    unique case (c)
      CYC_LOCAL_FETCH: r.inta_n = 1'b0;
      CYC_LOCAL_READ: r.io_read_n = 1'b0;
      CYC_LOCAL_WRITE: r.local_write_strobe_n = 1'b0;
      CYC_SYS_FETCH, CYC_SYS_READ: r.mem_read_n = 1'b0;
      CYC_SYS_WRITE: r.mem_write_n = 1'b0;
      CYC_HALT, CYC_PASSIVE: r = '{default: 1'b1};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Lane steering
  // Lane enables from memory width and latched address bit zero
  function automatic lanes_s steer_lanes(input logic en, input logic wide,
                                         input logic a0);
    lanes_s l;
    l = '{default: 1'b1};
    if (en) begin
      // Even address: low path, and the high path too on wide memory
      l.low_lane_enable_n = a0;
      l.high_lane_enable_n = a0 || !wide;
      // Odd address: swap path alone carries the byte to the high lane
      l.swap_lane_enable_n = !a0;
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wake-up command decode
  // Command byte to {clear, attention, reset}; other bytes do nothing
  function automatic logic [2:0] wake_action(input logic [7:0] b);
    logic [2:0] act;
    act = 3'h0;
    unique case (b)
      `CMD_CLEAR: act = 3'h4;
      `CMD_ATTN: act = 3'h2;
      `CMD_RESET: act = 3'h1;
      default: act = 3'h0;
    endcase
    return act;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Initialization fetch decode
  // Fetch named by the latched address, as {jumpers, zeros, width}
  function automatic logic [2:0] init_slot(input logic [19:0] a, input logic rd,
                                           input logic done);
    logic live;
    live = rd && !done; // only until the jumper fetch ends the sequence; board reset restarts it
    return {live && a[19:1] == `INIT_ADDR_JMP,
            live && a[19:1] == `INIT_ADDR_ZERO,
            live && a == `INIT_ADDR_WIDTH};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset image
  // Values held in reset; the board itself stays in reset after power-up
  function automatic state_s reset_state();
    state_s s;
    s = '0;
    s.cmd = '{default: 1'b1};
    s.lanes = '{default: 1'b1};
    s.local_xcvr_enable_n = 1'b1;
    s.port_match_n = 1'b1;
    s.board_reset_n = `RESET_BOARD_N;
    s.attention_input = `RESET_ATTN;
    s.irq_latch = `RESET_IRQ;
    s.host_irq_n = !`RESET_IRQ;
    s.jumper_read_gate_n = 1'b1;
    return s;
  endfunction

  // One constant shared by the asynchronous and the released-reset branch
  localparam state_s RESET_ST = reset_state();

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  assign rst_n = st.rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic sys_cycle;
    logic is_width;
    logic is_zero;
    logic is_jmp;
    logic hit;
    logic [2:0] act;
    sys_cycle = 1'b0;
    is_width = 1'b0;
    is_zero = 1'b0;
    is_jmp = 1'b0;
    hit = 1'b0;
    act = 3'h0;
    // Hold everything unless a rule below changes it
    next_st = st;
    // Shift ones into the reset synchroniser
    next_st.rst_sync = {st.rst_sync[0], 1'b1};
    // Command strobes follow the cycle code one clock later
    next_st.cmd = decode_cycle(cycle_status_i);
    // Latch the multiplexed address on each cycle start
    if (ale_i) begin
      next_st.sys_addr = proc_addr_i;
      next_st.local_addr = proc_addr_i;
    end
    // Transceiver controls pass through one flop
    next_st.xcvr_direction = dt_r_i;
    next_st.system_xcvr_enable = den_i;
    next_st.local_xcvr_enable_n = local_xcvr_enable_n_n_i;
    // Byte lane steering by memory width and address bit zero
    next_st.lanes = steer_lanes(den_i, mem_16bit_i, st.sys_addr[0]);
    // Wake-up port compare and command decode
    hit = host_io_write_i &&
          addr_hit(host_io_addr_i, wake_jumper_i, io_16bit_jumper_i);
    next_st.port_match_n = !hit;
    act = hit ? wake_action(host_data_i) : 3'h0;
    next_st.attention_input = act[1];
    if (act[2]) begin
      next_st.board_reset_n = 1'b1;
      next_st.irq_latch = 1'b0;
    end
    if (act[0]) begin
      next_st.board_reset_n = 1'b0;
    end
    // Interrupt set wins over a same-cycle clear command; board reset still clears it
    if (!irq_port_write_n_i && proc_data_i[`IRQ_DATA_BIT]) begin
      next_st.irq_latch = 1'b1;
    end
    if (!st.board_reset_n) begin
      next_st.irq_latch = 1'b0;
    end
    // Host line driven low while the latch is set
    next_st.host_irq_n = !next_st.irq_latch;
    // On-board answers to initialization fetches
    sys_cycle = !st.cmd.mem_read_n;
    {is_jmp, is_zero, is_width} = init_slot(st.sys_addr, sys_cycle, st.init_done);
    next_st.init_ack = is_width || is_zero || is_jmp;
    next_st.jumper_read_gate_n = !is_jmp;
    if (is_width) begin
      next_st.init_data = {15'h0000, width_16_jumper_i};
    end else if (is_jmp) begin
      next_st.init_data = wake_jumper_i; // shifted by processor
    end else begin
      next_st.init_data = 16'h0000;
    end
    if (is_jmp) begin
      next_st.init_done = 1'b1;
    end
    // Page jumper passed on to the block address logic
    next_st.block_page_last = last_page_jumper_i;
    // Board reset restarts the initialization sequence
    if (!st.board_reset_n) begin
      next_st.init_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; everything but the synchroniser uses released reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= RESET_ST;
    end else if (!rst_n) begin
      // Held in reset until ones reach the synchroniser's second flop
      st <= RESET_ST;
      st.rst_sync <= next_st.rst_sync;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign inta_n_o = st.cmd.inta_n;
  assign io_read_n_o = st.cmd.io_read_n;
  assign local_write_strobe_n_o = st.cmd.local_write_strobe_n;
  assign mem_read_n_o = st.cmd.mem_read_n;
  assign mem_write_n_o = st.cmd.mem_write_n;

  // Address and transceiver controls
  assign sys_addr_o = st.sys_addr;
  assign local_addr_o = st.local_addr;
  assign xcvr_direction_o = st.xcvr_direction;
  assign system_xcvr_enable_o = st.system_xcvr_enable;
  assign local_xcvr_enable_n_o = st.local_xcvr_enable_n;

  // Byte lane enables
  assign high_lane_enable_n_o = st.lanes.high_lane_enable_n;
  assign low_lane_enable_n_o = st.lanes.low_lane_enable_n;
  assign swap_lane_enable_n_o = st.lanes.swap_lane_enable_n;

  // Wake-up port, board reset and host interrupt
  assign port_match_n_o = st.port_match_n;
  assign board_reset_n_o = st.board_reset_n;
  assign attention_input_o = st.attention_input;
  assign host_irq_n_o = st.host_irq_n;

  // Initialization answers and page select
  assign jumper_read_gate_n_o = st.jumper_read_gate_n;
  assign init_ack_o = st.init_ack;
  assign init_data_o = st.init_data;
  assign block_page_last_o = st.block_page_last;
endmodule

// ===== rtl/wake_port_pkg.sv
// Types of the host wake-up port logic
package wake_port_pkg;
  typedef enum logic [2:0] {
    CYC_LOCAL_FETCH = 3'h0,
    CYC_LOCAL_READ = 3'h1,
    CYC_LOCAL_WRITE = 3'h2,
    CYC_HALT = 3'h3,
    CYC_SYS_FETCH = 3'h4,
    CYC_SYS_READ = 3'h5,
    CYC_SYS_WRITE = 3'h6,
    CYC_PASSIVE = 3'h7
  } cycle_e;

  typedef struct packed {
    logic inta_n;
    logic io_read_n;
    logic local_write_strobe_n;
    logic mem_read_n;
    logic mem_write_n;
  } cmd_s;

  typedef struct packed {
    logic high_lane_enable_n;
    logic low_lane_enable_n;
    logic swap_lane_enable_n;
  } lanes_s;

  typedef struct packed {
    logic [1:0] rst_sync;
    cmd_s cmd;
    lanes_s lanes;
    logic [19:0] sys_addr;
    logic [19:0] local_addr;
    logic xcvr_direction;
    logic system_xcvr_enable;
    logic local_xcvr_enable_n;
    logic port_match_n;
    logic board_reset_n;
    logic attention_input;
    logic irq_latch;
    logic host_irq_n;
    logic jumper_read_gate_n;
    logic init_ack;
    logic [15:0] init_data;
    logic init_done;
    logic block_page_last;
  } state_s;
endpackage

// ===== rtl/wake_port_regs.svh
// Constants of the host wake-up port logic
`ifndef WAKE_PORT_REGS_SVH
`define WAKE_PORT_REGS_SVH
`define CMD_CLEAR 8'h00
`define CMD_ATTN 8'h01
`define CMD_RESET 8'h02
`define INIT_ADDR_WIDTH 20'hffff6
`define INIT_ADDR_ZERO 19'h7fffc
`define INIT_ADDR_JMP 19'h7fffd
`define IRQ_DATA_BIT 8
`define RESET_ATTN 1'b0
`define RESET_IRQ 1'b0
`define RESET_BOARD_N 1'b0
`endif

// ===== test/host_cpu_model.sv
// Host processor model writing the wake-up port
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic sys_clk_i,
  output logic host_io_write_o,
  output logic [15:0] host_io_addr_o,
  output logic [7:0] host_data_o
);
  initial begin
    host_io_write_o = 1'b0;
    host_io_addr_o = 16'hffff;
    host_data_o = 8'hff;
  end
  // One host I/O write, then the released lines flip away from the last value
  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    host_io_write_o = 1'b1;
    host_io_addr_o = addr;
    host_data_o = data;
    @(negedge sys_clk_i);
    host_io_write_o = 1'b0;
    host_io_addr_o = ~addr;
    host_data_o = ~data;
  endtask
endmodule

// ===== test/host_port_match_n_port_logic_props.sv
// Port assertions of the host wake-up port logic
`timescale 1ns/1ps
module host_port_match_n_port_logic_props (
  input wire logic sys_clk_i, arst_n_i, ale_i, dt_r_i, den_i, irq_port_write_n_i,
  input wire wake_port_pkg::cycle_e cycle_status_i,
  input wire logic [19:0] proc_addr_i, sys_addr_o, local_addr_o,
  input wire logic [15:0] proc_data_i, host_io_addr_i, wake_jumper_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_io_write_i, io_16bit_jumper_i, inta_n_o, io_read_n_o,
  input wire logic mem_read_n_o, mem_write_n_o, xcvr_direction_o, system_xcvr_enable_o,
  input wire logic port_match_n_o, board_reset_n_o, attention_input_o, host_irq_n_o
);
  import wake_port_pkg::*;
  logic [1:0] up;
  logic hit;
  // Edges since reset release; the design sits out its synchroniser first
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  // Host write aimed at the wake-up port
  assign hit = host_io_write_i && host_io_addr_i[7:0] == wake_jumper_i[7:0] &&
    (!io_16bit_jumper_i || host_io_addr_i[15:8] == wake_jumper_i[15:8]);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (up != 2'h3);
  sequence s_cmd(logic [7:0] b);
    hit && host_data_i == b;
  endsequence
  AST_FETCH: assert property (cycle_status_i == CYC_LOCAL_FETCH |=> !inta_n_o)
    else $error("local fetch gave no acknowledge strobe");
  AST_SYSRD: assert property (cycle_status_i inside {CYC_SYS_FETCH, CYC_SYS_READ} |=>
    !mem_read_n_o && io_read_n_o) else $error("system read strobe wrong");
  AST_SYSWR: assert property (cycle_status_i == CYC_SYS_WRITE |=> !mem_write_n_o)
    else $error("system write strobe missing");
  AST_IDLE: assert property (cycle_status_i inside {CYC_HALT, CYC_PASSIVE} |=>
    inta_n_o && io_read_n_o && mem_read_n_o && mem_write_n_o) else $error("idle gave strobe");
  AST_ALE: assert property (ale_i |=> sys_addr_o == $past(proc_addr_i) &&
    local_addr_o == $past(proc_addr_i)) else $error("address not latched");
  AST_DIR: assert property (1 |=> xcvr_direction_o == $past(dt_r_i) &&
    system_xcvr_enable_o == $past(den_i)) else $error("transceiver control wrong");
  AST_QUIET: assert property (!hit |=> port_match_n_o && !attention_input_o)
    else $error("wake strobe without matching write");
  AST_MATCH: assert property (hit |=> !port_match_n_o)
    else $error("matching write gave no wake strobe");
  AST_RSTCMD: assert property (s_cmd(8'h02) |=> !board_reset_n_o)
    else $error("reset command ignored");
  AST_RSTHOLD: assert property (!board_reset_n_o && !(hit && host_data_i == 8'h00) |=>
    !board_reset_n_o) else $error("board reset released early");
  AST_CLR: assert property (s_cmd(8'h00) ##0 irq_port_write_n_i |=>
    board_reset_n_o && host_irq_n_o) else $error("clear command ignored");
  AST_ATTN: assert property (s_cmd(8'h01) |=> attention_input_o)
    else $error("attention command ignored");
  AST_IRQ: assert property (!irq_port_write_n_i && proc_data_i[8] |=> !host_irq_n_o)
    else $error("interrupt not raised");
endmodule
bind host_port_match_n_port_logic host_port_match_n_port_logic_props props (.*);

// ===== test/host_port_match_n_port_logic_tb.sv
// Self-checking bench of the host wake-up port logic
`timescale 1ns/1ps
module host_port_match_n_port_logic_tb;
  import wake_port_pkg::*;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, ale_i = 1'b0, dt_r_i = 1'b0, den_i = 1'b0;
  logic local_xcvr_enable_n_n_i = 1'b1, mem_16bit_i = 1'b0, irq_port_write_n_i = 1'b1, host_io_write_i;
  logic io_16bit_jumper_i = 1'b1, width_16_jumper_i = 1'b1, last_page_jumper_i = 1'b1;
  cycle_e cycle_status_i = CYC_PASSIVE;
  logic [19:0] proc_addr_i = 20'h0, sys_addr_o, local_addr_o, r;
  logic [15:0] proc_data_i = 16'h0, wake_jumper_i = 16'h0, host_io_addr_i, init_data_o;
  logic [7:0] host_data_i;
  logic inta_n_o, io_read_n_o, local_write_strobe_n_o, mem_read_n_o, mem_write_n_o;
  logic xcvr_direction_o, system_xcvr_enable_o, local_xcvr_enable_n_o, high_lane_enable_n_o;
  logic low_lane_enable_n_o, swap_lane_enable_n_o, port_match_n_o, board_reset_n_o;
  logic attention_input_o, host_irq_n_o, jumper_read_gate_n_o, init_ack_o, block_page_last_o;
  int miscompares = 0, n_checks = 0;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  host_port_match_n_port_logic uut (.*);
  host_cpu_model host (.sys_clk_i(sys_clk_i), .host_io_write_o(host_io_write_i),
    .host_io_addr_o(host_io_addr_i), .host_data_o(host_data_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Strobes {inta, io_read, local_write, mem_read, mem_write} per cycle code
  function automatic logic [4:0] strobes(input cycle_e c);
    case (c)
      CYC_LOCAL_FETCH: return 5'h0f;
      CYC_LOCAL_READ: return 5'h17;
      CYC_LOCAL_WRITE: return 5'h1b;
      CYC_SYS_FETCH, CYC_SYS_READ: return 5'h1d;
      CYC_SYS_WRITE: return 5'h1e;
      default: return 5'h1f;
    endcase
  endfunction
  // Lane enables {high, low, swap}
  function automatic logic [2:0] lanes(input logic en, m16, a0);
    return !en ? 3'h7 : a0 ? 3'h6 : {~m16, 2'h1};
  endfunction
  task automatic raise_irq();
    proc_data_i = 16'h0100;
    irq_port_write_n_i = 1'b0;
    @(negedge sys_clk_i);
    irq_port_write_n_i = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h65c2));
    repeat (16) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    wake_jumper_i = 16'($urandom);
    width_16_jumper_i = 1'($urandom);
    repeat (3) @(negedge sys_clk_i);
    chk({board_reset_n_o, host_irq_n_o, block_page_last_o}, 3'h3);
    host.io_write(wake_jumper_i ^ 16'h0100, 8'h00);
    chk({port_match_n_o, board_reset_n_o}, 2'h2);
    io_16bit_jumper_i = 1'b0;
    host.io_write(wake_jumper_i ^ 16'h0100, 8'h00);
    chk({port_match_n_o, board_reset_n_o}, 2'h1);
    host.io_write(wake_jumper_i, 8'h01);
    chk(attention_input_o, 1'b1);
    host.io_write(wake_jumper_i, 8'h05);
    chk({port_match_n_o, attention_input_o, board_reset_n_o}, 3'h1);
    raise_irq();
    chk(host_irq_n_o, 1'b0);
    host.io_write(wake_jumper_i, 8'h00);
    chk(host_irq_n_o, 1'b1);
    for (int k = 0; k < 3; k++) begin
      ale_i = 1'b1;
      proc_addr_i = 20'hffff6 + 20'(2 * k);
      @(negedge sys_clk_i);
      ale_i = 1'b0;
      cycle_status_i = CYC_SYS_READ;
      r = 20'hfffff;
      for (int t = 0; t < 8 && r == 20'hfffff; t++) begin
        @(negedge sys_clk_i);
        if (init_ack_o === 1'b1) r = {3'h0, jumper_read_gate_n_o, init_data_o};
      end
      chk(r, {3'h0, k != 2, k == 0 ? {15'h0, width_16_jumper_i} :
        k == 1 ? 16'h0 : wake_jumper_i});
      if (r == 20'hfffff) final_report();
      cycle_status_i = CYC_PASSIVE;
      @(negedge sys_clk_i);
    end
    for (int i = 0; i < 8; i++) begin
      cycle_status_i = cycle_e'(i);
      @(negedge sys_clk_i);
      chk({inta_n_o, io_read_n_o, local_write_strobe_n_o, mem_read_n_o, mem_write_n_o},
        strobes(cycle_status_i));
    end
    cycle_status_i = CYC_PASSIVE;
    for (int i = 0; i < 24; i++) begin
      r = 20'($urandom);
      {dt_r_i, den_i, local_xcvr_enable_n_n_i, mem_16bit_i, last_page_jumper_i} = 5'($urandom);
      proc_addr_i = r;
      ale_i = 1'b1;
      @(negedge sys_clk_i);
      ale_i = 1'b0;
      proc_addr_i = ~r;
      @(negedge sys_clk_i);
      chk(sys_addr_o, r);
      chk(local_addr_o, r);
      chk(block_page_last_o, last_page_jumper_i);
      chk({xcvr_direction_o, system_xcvr_enable_o, local_xcvr_enable_n_o},
        {dt_r_i, den_i, local_xcvr_enable_n_n_i});
      chk({high_lane_enable_n_o, low_lane_enable_n_o, swap_lane_enable_n_o},
        lanes(den_i, mem_16bit_i, r[0]));
    end
    raise_irq();
    host.io_write(wake_jumper_i, 8'h02);
    chk({board_reset_n_o, host_irq_n_o}, 2'h0);
    @(negedge sys_clk_i);
    chk({board_reset_n_o, host_irq_n_o}, 2'h1);
    final_report();
  end
endmodule
